//--- sbm_pkg.sv
/*
 package for the split data bus mode select block: widths, strap encoding,
 chip-select port size codes, lane masks, memory reach and the pin owner states.
 assumes it is compiled before every other file of the block.
*/
package sbm_pkg;

   // ==========================================================================
   // widths
   localparam int DATA_W = 32;
   localparam int ADDR_W = 24;
   localparam int HALF_W = 16;

   // ==========================================================================
   // strap encoding, pin high selects the shared bus
   localparam logic MODE_SHARED = 1'b1;
   localparam logic MODE_SPLIT  = 1'b0;
   localparam logic MODE_RESET  = MODE_SHARED;

   // ==========================================================================
   // chip-select bus port sizes
   localparam logic [1:0] SIZE_32 = 2'h0;
   localparam logic [1:0] SIZE_8  = 2'h1;
   localparam logic [1:0] SIZE_16 = 2'h2;

   // ==========================================================================
   // data lane masks
   localparam logic [DATA_W-1:0] LANES_ALL   = 32'hffffffff;
   localparam logic [DATA_W-1:0] LANES_NONE  = 32'h00000000;
   localparam logic [DATA_W-1:0] LANES_UPPER = 32'hffff0000;
   localparam logic [DATA_W-1:0] LANES_LOWER = 32'h0000ffff;
   localparam logic [DATA_W-1:0] LANES_BYTE  = 32'h000000ff;

   // ==========================================================================
   // memory reach, identical in both modes
   localparam longint FLASH_MAX_BYTES = 64'h0000000001000000;
   localparam longint SDRAM_MAX_BYTES = 64'h0000000010000000;
   localparam int     CS_SPAN_W       = $clog2(FLASH_MAX_BYTES);
   localparam int     SD_SPAN_W       = $clog2(SDRAM_MAX_BYTES);
   localparam int     SD_CS_NUM       = 2;

   // ==========================================================================
   // pin owner, gray along idle->sdram and idle->chip-select bus
   typedef enum logic [1:0] {
      OWN_IDLE  = 2'h0,
      OWN_SDRAM = 2'h1,
      OWN_CSBUS = 2'h2
   } sbm_owner_type;

   // lanes an owner may use for the captured mode and port size
   function automatic logic [DATA_W-1:0] sbm_lane_mask(input logic          mode,
                                                       input sbm_owner_type own,
                                                       input logic [1:0]    size);
      logic [DATA_W-1:0] m;
      m = LANES_NONE;
      if (own == OWN_SDRAM) begin
         m = (mode == MODE_SHARED) ? LANES_ALL : LANES_UPPER;
      end else if (own == OWN_CSBUS) begin
         if (size == SIZE_8) begin
            m = LANES_BYTE;
         end else if (size == SIZE_32 && mode == MODE_SHARED) begin
            m = LANES_ALL;
         end else begin
            m = LANES_LOWER;
         end
      end
      return m;
   endfunction

endpackage

//--- sbm_cap_if.sv
/*
 carrier between the pin steering logic and the sdram read capture.
 assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps

interface sbm_cap_if;
   import sbm_pkg::*;
   logic              rd_en;
   logic              mode;
   logic [DATA_W-1:0] pins;
   logic [1:0]        strobes;
   logic [DATA_W-1:0] rdata;
   logic              rvalid;

   modport ctrl (output rd_en, output mode, output pins, output strobes,
                 input rdata, input rvalid);
   modport cap  (input rd_en, input mode, input pins, input strobes,
                 output rdata, output rvalid);
endinterface

//--- sbm_read_capture.sv
/*
 sdram read capture: latches the data pins on a rising edge of either read strobe.
 assumes strobe inputs are synchronous to the system clock.
*/
`timescale 1ns/1ps

module sbm_read_capture
   import sbm_pkg::*;
(
   input  wire logic clk_sys_in,
   input  wire logic rst_n_in,
   sbm_cap_if.cap    cap
);

   // ==========================================================================
   // strobe edge
   logic [1:0]        stb_q;
   logic              rise;
   logic [DATA_W-1:0] rdata_q;
   logic              rvalid_q;

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stb_q <= 2'h0;
      end else begin
         stb_q <= cap.strobes;
      end
   end

   // either lane strobe marks data valid; the looped strobe reaches both
   assign rise = |(cap.strobes & ~stb_q);

   // ==========================================================================
   // capture
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_q  <= LANES_NONE;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= rise && cap.rd_en;
         if (rise && cap.rd_en) begin
            rdata_q <= cap.pins & sbm_lane_mask(cap.mode, OWN_SDRAM, SIZE_32);
         end
      end
   end

   assign cap.rdata  = rdata_q;
   assign cap.rvalid = rvalid_q;

   // ==========================================================================
   // checks
   property p_strobe_capture;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      (rise && cap.rd_en) |=> rvalid_q ##1 (!rvalid_q || $past(rise && cap.rd_en));
   endproperty
   a_strobe_capture: assert property (p_strobe_capture)
      else $error("read strobe edge did not capture data");

   property p_no_capture_idle;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      !cap.rd_en |=> !rvalid_q;
   endproperty
   a_no_capture_idle: assert property (p_no_capture_idle)
      else $error("read data captured without an sdram read");

endmodule

//--- sbm_bus_mux.sv
/*
 split data bus mode select: steers the shared 32-bit data and 24-bit address
 pins between the sdram controller and the chip-select bus.
 assumes both requesters hold their request level for the whole access and
 present pin values for their own access; pins are synchronous to clk_sys_in.
*/
`timescale 1ns/1ps

module sbm_bus_mux
   import sbm_pkg::*;
(
   input  wire logic                 clk_sys_in,
   input  wire logic                 rst_n_in,
   input  wire logic                 bus_mode_select_pin_in,
   // sdram controller side
   input  wire logic                 sd_req_in,
   input  wire logic                 sd_we_in,
   input  wire logic [ADDR_W-1:0]    sd_addr_in,
   input  wire logic [DATA_W-1:0]    sd_wdata_in,
   input  wire logic [SD_CS_NUM-1:0] sd_cs_sel_in,
   input  wire logic                 sd_strobe_req_in,
   output logic                      sd_grant_out,
   output logic [DATA_W-1:0]         sd_rdata_out,
   output logic                      sd_rvalid_out,
   // chip-select bus side
   input  wire logic                 cs_req_in,
   input  wire logic                 cs_we_in,
   input  wire logic                 cs_boot_sel_in,
   input  wire logic [1:0]           cs_size_in,
   input  wire logic [ADDR_W-1:0]    cs_addr_in,
   input  wire logic [DATA_W-1:0]    cs_wdata_in,
   input  wire logic                 cs_rd_sample_in,
   output logic                      cs_grant_out,
   output logic [DATA_W-1:0]         cs_rdata_out,
   output logic                      cs_rvalid_out,
   output logic                      cs_size_err_out,
   // pins
   output logic [ADDR_W-1:0]         addr_pins_out,
   input  wire logic [DATA_W-1:0]    data_pins_in,
   output logic [DATA_W-1:0]         data_pins_out,
   output logic [DATA_W-1:0]         data_oe_n_out,
   output logic [SD_CS_NUM-1:0]      sd_cs_n_out,
   output logic                      boot_cs_n_out,
   input  wire logic [1:0]           read_strobe_inputs_in,
   output logic                      loopback_strobe_out,
   output logic                      mode_split_out
);

   // ==========================================================================
   // mode strap
   logic mode_q;
   logic lock_q;

   // strap is taken by the first clock after release, never by the reset itself
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mode_q <= MODE_RESET;
         lock_q <= 1'b0;
      end else if (!lock_q) begin
         mode_q <= bus_mode_select_pin_in;
         lock_q <= 1'b1;
      end
   end
   // once locked nothing writes mode_q again

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mode_split_out <= 1'b0;
      end else begin
         mode_split_out <= lock_q && (mode_q == MODE_SPLIT);
      end
   end

   // ==========================================================================
   // owner of the shared pins
   sbm_owner_type     owner_q;
   sbm_owner_type     owner_d;
   logic              last_sd_q;
   logic [DATA_W-1:0] mask_d;
   logic              we_d;

   // address pins are common, so even split mode runs one access at a time
   always_comb begin
      owner_d = owner_q;
      unique case (owner_q)
         OWN_IDLE: begin
            if (lock_q && sd_req_in && (!cs_req_in || !last_sd_q)) begin
               owner_d = OWN_SDRAM;
            end else if (lock_q && cs_req_in) begin
               owner_d = OWN_CSBUS;
            end
         end
         OWN_SDRAM: begin
            if (!sd_req_in) begin
               owner_d = OWN_IDLE;
            end
         end
         OWN_CSBUS: begin
            if (!cs_req_in) begin
               owner_d = OWN_IDLE;
            end
         end
         default: begin
            owner_d = OWN_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         owner_q   <= OWN_IDLE;
         last_sd_q <= 1'b0;
      end else begin
         owner_q <= owner_d;
         if (owner_d == OWN_SDRAM) begin
            last_sd_q <= 1'b1;
         end else if (owner_d == OWN_CSBUS) begin
            last_sd_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sd_grant_out <= 1'b0;
         cs_grant_out <= 1'b0;
      end else begin
         sd_grant_out <= (owner_d == OWN_SDRAM);
         cs_grant_out <= (owner_d == OWN_CSBUS);
      end
   end

   // ==========================================================================
   // lane steering
   assign mask_d = sbm_lane_mask(mode_q, owner_d, cs_size_in);
   assign we_d   = (owner_d == OWN_SDRAM) ? sd_we_in : (owner_d == OWN_CSBUS) && cs_we_in;

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         data_oe_n_out <= LANES_ALL;
         data_pins_out <= LANES_NONE;
      end else begin
         data_oe_n_out <= ~(mask_d & {DATA_W{we_d}});
         if (owner_d == OWN_SDRAM) begin
            data_pins_out <= sd_wdata_in & mask_d;
         end else if (owner_d == OWN_CSBUS) begin
            data_pins_out <= cs_wdata_in & mask_d;
         end
      end
   end

   // a 32-bit port in split mode is undefined; it is flagged and run as 16-bit
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cs_size_err_out <= 1'b0;
      end else begin
         cs_size_err_out <= (owner_d == OWN_CSBUS) && (mode_q == MODE_SPLIT) &&
                            (cs_size_in == SIZE_32);
      end
   end

   // ==========================================================================
   // address and selects, mode does not change the reach
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         addr_pins_out <= '0;
         sd_cs_n_out   <= '1;
         boot_cs_n_out <= 1'b1;
      end else begin
         if (owner_d == OWN_SDRAM) begin
            addr_pins_out <= sd_addr_in;
         end else if (owner_d == OWN_CSBUS) begin
            addr_pins_out <= cs_addr_in[CS_SPAN_W-1:0];
         end
         sd_cs_n_out   <= (owner_d == OWN_SDRAM) ? ~sd_cs_sel_in : '1;
         boot_cs_n_out <= !((owner_d == OWN_CSBUS) && cs_boot_sel_in);
      end
   end

   // ==========================================================================
   // read paths
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cs_rdata_out  <= LANES_NONE;
         cs_rvalid_out <= 1'b0;
      end else begin
         cs_rvalid_out <= (owner_q == OWN_CSBUS) && !cs_we_in && cs_rd_sample_in;
         if ((owner_q == OWN_CSBUS) && !cs_we_in && cs_rd_sample_in) begin
            cs_rdata_out <= data_pins_in & sbm_lane_mask(mode_q, OWN_CSBUS, cs_size_in);
         end
      end
   end

   // single-rate parts give no strobe, so one is made here and looped back
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         loopback_strobe_out <= 1'b0;
      end else begin
         loopback_strobe_out <= (owner_q == OWN_SDRAM) && !sd_we_in && sd_strobe_req_in;
      end
   end

   sbm_cap_if cap_bus ();

   assign cap_bus.rd_en   = (owner_q == OWN_SDRAM) && !sd_we_in;
   assign cap_bus.mode    = mode_q;
   assign cap_bus.pins    = data_pins_in;
   assign cap_bus.strobes = read_strobe_inputs_in;

   sbm_read_capture u_capture (
      .clk_sys_in (clk_sys_in),
      .rst_n_in   (rst_n_in),
      .cap        (cap_bus.cap)
   );

   assign sd_rdata_out  = cap_bus.rdata;
   assign sd_rvalid_out = cap_bus.rvalid;

   // ==========================================================================
   // checks
   property p_mode_capture;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      $rose(lock_q) |-> mode_q == $past(bus_mode_select_pin_in);
   endproperty
   a_mode_capture: assert property (p_mode_capture)
      else $error("strap level not captured at reset release");

   property p_mode_hold;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      lock_q |=> $stable(mode_q) && lock_q;
   endproperty
   a_mode_hold: assert property (p_mode_hold)
      else $error("bus mode changed after capture");

   property p_shared_full;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      (lock_q && mode_q == MODE_SHARED && owner_d == OWN_SDRAM && sd_we_in)
         |=> data_oe_n_out == LANES_NONE && sd_grant_out;
   endproperty
   a_shared_full: assert property (p_shared_full)
      else $error("shared mode sdram write not on all lanes");

   property p_split_sd_lanes;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      (mode_q == MODE_SPLIT && sd_grant_out) |-> &data_oe_n_out[HALF_W-1:0];
   endproperty
   a_split_sd_lanes: assert property (p_split_sd_lanes)
      else $error("sdram drove lower lanes in split mode");

   property p_split_cs_lanes;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      (mode_q == MODE_SPLIT && cs_grant_out) |-> &data_oe_n_out[DATA_W-1:HALF_W];
   endproperty
   a_split_cs_lanes: assert property (p_split_cs_lanes)
      else $error("chip-select bus drove upper lanes in split mode");

   property p_shared_32;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      (mode_q == MODE_SHARED && owner_d == OWN_CSBUS && cs_we_in && cs_size_in == SIZE_32)
         |=> data_oe_n_out == LANES_NONE && !cs_size_err_out;
   endproperty
   a_shared_32: assert property (p_shared_32)
      else $error("32-bit port not driven in shared mode");

   property p_split_size_err;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      (mode_q == MODE_SPLIT && owner_d == OWN_CSBUS && cs_size_in == SIZE_32)
         |=> cs_size_err_out && &data_oe_n_out[DATA_W-1:HALF_W];
   endproperty
   a_split_size_err: assert property (p_split_size_err)
      else $error("32-bit port in split mode not flagged");

   property p_no_overlap;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      !(sd_grant_out && cs_grant_out) && !($fell(sd_grant_out) && cs_grant_out);
   endproperty
   a_no_overlap: assert property (p_no_overlap)
      else $error("sdram and chip-select accesses overlap");

   property p_addr_follow;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      (owner_d == OWN_CSBUS) |=> addr_pins_out == $past(cs_addr_in) && cs_grant_out;
   endproperty
   a_addr_follow: assert property (p_addr_follow)
      else $error("address pins do not follow the chip-select bus");

   property p_loopback;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      (owner_q == OWN_SDRAM && !sd_we_in && sd_strobe_req_in) |=> loopback_strobe_out;
   endproperty
   a_loopback: assert property (p_loopback)
      else $error("loopback strobe not generated");

   c_shared_sd_write: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      mode_q == MODE_SHARED && sd_grant_out && data_oe_n_out == LANES_NONE);
   c_split_cs_read: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      mode_q == MODE_SPLIT && cs_rvalid_out);
   c_size_err: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      cs_size_err_out);
   c_handover: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      $fell(sd_grant_out) ##[1:3] cs_grant_out);

endmodule

//--- sbm_mem_model.sv
/*
 external memory model: sdram on the sdram selects, flash on the boot select.
 assumes pins are registered on clk_sys_in and strobe_in is the loopback output.
*/
`timescale 1ns/1ps

module sbm_mem_model
   import sbm_pkg::*;
(
   input  wire logic                 clk_sys_in,
   input  wire logic [ADDR_W-1:0]    addr_in,
   input  wire logic [DATA_W-1:0]    data_in,
   input  wire logic [DATA_W-1:0]    oe_n_in,
   input  wire logic [SD_CS_NUM-1:0] sd_cs_n_in,
   input  wire logic                 boot_cs_n_in,
   input  wire logic                 strobe_in,
   output logic      [DATA_W-1:0]    data_out,
   output logic      [1:0]           strobe_out
);
   // ==========================================================================
   // storage, four words each keeps the model small
   logic [DATA_W-1:0] sd_mem [4];
   logic [DATA_W-1:0] cs_mem [4];
   logic [DATA_W-1:0] idle_q;
   logic              sd_on;
   logic              cs_on;
   logic [1:0]        a;

   // lower half preset non-zero so an unmasked split-mode sdram read shows
   initial begin
      idle_q = 32'h5a5aa5a5;
      for (int i = 0; i < 4; i++) begin
         sd_mem[i] = 32'h0000c3c3;
         cs_mem[i] = 32'h0;
      end
   end

   assign sd_on = (sd_cs_n_in != 2'h3);
   assign cs_on = !boot_cs_n_in;
   assign a     = addr_in[1:0];
   // single-rate parts give no strobe, so the generated one comes straight back
   assign strobe_out = {2{strobe_in}};
   // a released bus toggles every cycle so a stale value never passes
   assign data_out = (oe_n_in !== LANES_ALL) ? idle_q :
                     sd_on ? sd_mem[a] : cs_on ? cs_mem[a] : idle_q;

   // ==========================================================================
   // writes merge only the driven lanes
   always @(posedge clk_sys_in) begin
      idle_q <= ~idle_q;
      if (sd_on && oe_n_in != LANES_ALL) begin
         sd_mem[a] <= (sd_mem[a] & oe_n_in) | (data_in & ~oe_n_in);
      end
      if (cs_on && oe_n_in != LANES_ALL) begin
         cs_mem[a] <= (cs_mem[a] & oe_n_in) | (data_in & ~oe_n_in);
      end
   end
endmodule

//--- sbm_bus_mux_tb.sv
/*
 self-checking bench for sbm_bus_mux with the external memory model.
 assumes inputs change on the falling edge and outputs settle before it.
*/
`timescale 1ns/1ps

module sbm_bus_mux_tb
   import sbm_pkg::*;
;
   logic                 clk_sys_in;
   logic                 rst_n_in;
   logic                 pin;
   logic                 sd_req, sd_we, sd_strq, sd_gnt, sd_rv;
   logic                 cs_req, cs_we, cs_boot, cs_smp, cs_gnt, cs_rv, cs_err;
   logic                 boot_cs_n, lb, split;
   logic [ADDR_W-1:0]    sd_addr, cs_addr, addr_pins;
   logic [DATA_W-1:0]    sd_wd, cs_wd, din, dout, oe_n, sd_rd, cs_rd;
   logic [SD_CS_NUM-1:0] sd_sel, sd_cs_n;
   logic [1:0]           cs_size, strb;
   int                   bad_count;
   int                   checked;

   sbm_bus_mux dut_u (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
      .bus_mode_select_pin_in(pin), .sd_req_in(sd_req), .sd_we_in(sd_we),
      .sd_addr_in(sd_addr), .sd_wdata_in(sd_wd), .sd_cs_sel_in(sd_sel),
      .sd_strobe_req_in(sd_strq), .sd_grant_out(sd_gnt), .sd_rdata_out(sd_rd),
      .sd_rvalid_out(sd_rv), .cs_req_in(cs_req), .cs_we_in(cs_we),
      .cs_boot_sel_in(cs_boot), .cs_size_in(cs_size), .cs_addr_in(cs_addr),
      .cs_wdata_in(cs_wd), .cs_rd_sample_in(cs_smp), .cs_grant_out(cs_gnt),
      .cs_rdata_out(cs_rd), .cs_rvalid_out(cs_rv), .cs_size_err_out(cs_err),
      .addr_pins_out(addr_pins), .data_pins_in(din), .data_pins_out(dout),
      .data_oe_n_out(oe_n), .sd_cs_n_out(sd_cs_n), .boot_cs_n_out(boot_cs_n),
      .read_strobe_inputs_in(strb), .loopback_strobe_out(lb),
      .mode_split_out(split));

   sbm_mem_model mem_u (.clk_sys_in(clk_sys_in), .addr_in(addr_pins),
      .data_in(dout), .oe_n_in(oe_n), .sd_cs_n_in(sd_cs_n),
      .boot_cs_n_in(boot_cs_n), .strobe_in(lb), .data_out(din), .strobe_out(strb));

   // ==========================================================================
   // clock and shared tasks
   initial clk_sys_in = 1'b0;
   always #2 clk_sys_in = ~clk_sys_in;

   task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic do_reset(input logic p);
      rst_n_in = 1'b0;
      pin = p;
      repeat (12) @(negedge clk_sys_in);
      rst_n_in = 1'b1;
      repeat (2) @(negedge clk_sys_in);
      chk(split, p == MODE_SPLIT);
   endtask

   task automatic sd_open(input logic we, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d, input logic [1:0] s);
      sd_we = we;
      sd_addr = a;
      sd_wd = d;
      sd_sel = s;
      sd_req = 1'b1;
      @(negedge clk_sys_in);
      chk(sd_gnt, 1'b1);
      chk(addr_pins, a);
      chk(sd_cs_n, s ^ 2'h3);
   endtask

   task automatic cs_open(input logic we, input logic [1:0] sz,
                          input logic [DATA_W-1:0] d);
      cs_we = we;
      cs_size = sz;
      cs_wd = d;
      cs_req = 1'b1;
      @(negedge clk_sys_in);
      chk(cs_gnt, 1'b1);
      chk(boot_cs_n, 1'b0);
      chk(addr_pins, cs_addr);
   endtask

   task automatic rel;
      sd_req = 1'b0;
      cs_req = 1'b0;
      @(negedge clk_sys_in);
      chk({sd_gnt, cs_gnt}, 2'h0);
      chk(oe_n, LANES_ALL);
   endtask

   task automatic sd_read(input logic [ADDR_W-1:0] a, input logic [1:0] s,
                          input logic [DATA_W-1:0] e);
      sd_open(1'b0, a, 32'h0, s);
      sd_strq = 1'b1;
      @(negedge clk_sys_in);
      sd_strq = 1'b0;
      chk(lb, 1'b1);
      @(negedge clk_sys_in);
      chk(sd_rv, 1'b1);
      chk(sd_rd, e);
      rel();
      chk(sd_rv, 1'b0);
   endtask

   task automatic cs_read(input logic [1:0] sz, input logic [DATA_W-1:0] e);
      cs_open(1'b0, sz, 32'h0);
      cs_smp = 1'b1;
      @(negedge clk_sys_in);
      cs_smp = 1'b0;
      chk(cs_rv, 1'b1);
      chk(cs_rd, e);
      rel();
      chk(cs_rv, 1'b0);
   endtask

   // ==========================================================================
   // scenarios
   task automatic t_shared;
      logic [1:0]        szs [3] = '{SIZE_32, SIZE_16, SIZE_8};
      logic [DATA_W-1:0] msk [3] = '{LANES_ALL, LANES_LOWER, LANES_BYTE};
      do_reset(MODE_SHARED);
      for (int s = 1; s <= 2; s++) begin
         sd_open(1'b1, 24'hfffff0 + s, 32'hcafe0000 + s, s[1:0]);
         chk(oe_n, ~LANES_ALL);
         chk(dout, 32'hcafe0000 + s);
         rel();
         sd_read(24'hfffff0 + s, s[1:0], 32'hcafe0000 + s);
      end
      for (int i = 0; i < 3; i++) begin
         cs_open(1'b1, szs[i], 32'h89abcdef);
         chk(oe_n, ~msk[i]);
         chk(dout, 32'h89abcdef & msk[i]);
         rel();
         cs_read(szs[i], 32'h89abcdef & msk[i]);
      end
      $display("t_shared done");
   endtask

   task automatic t_split;
      logic [1:0]        szs [3] = '{SIZE_16, SIZE_8, SIZE_32};
      logic [DATA_W-1:0] msk [3] = '{LANES_LOWER, LANES_BYTE, LANES_LOWER};
      do_reset(MODE_SPLIT);
      pin = MODE_SHARED;
      repeat (3) @(negedge clk_sys_in);
      chk(split, 1'b1);
      sd_open(1'b1, 24'hffffff, 32'h1234abcd, 2'h1);
      chk(oe_n, ~LANES_UPPER);
      chk(dout, 32'h12340000);
      rel();
      sd_read(24'hffffff, 2'h1, 32'h12340000);
      for (int i = 0; i < 3; i++) begin
         cs_open(1'b1, szs[i], 32'h5566aa99);
         chk(oe_n, ~msk[i]);
         chk(dout, 32'h5566aa99 & msk[i]);
         @(negedge clk_sys_in);
         chk(cs_err, i == 2);
         rel();
         cs_read(szs[i], 32'h5566aa99 & msk[i]);
      end
      chk(split, 1'b1);
      $display("t_split done");
   endtask

   task automatic t_overlap;
      cs_req = 1'b1;
      sd_open(1'b0, 24'h000010, 32'h0, 2'h2);
      chk(cs_gnt, 1'b0);
      sd_req = 1'b0;
      @(negedge clk_sys_in);
      chk({sd_gnt, cs_gnt}, 2'h0);
      sd_req = 1'b1;
      cs_boot = 1'b0;
      @(negedge clk_sys_in);
      chk({sd_gnt, cs_gnt}, 2'h1);
      chk(boot_cs_n, 1'b1);
      rel();
      cs_boot = 1'b1;
      $display("t_overlap done");
   endtask

   // grants must never coexist, checked on every cycle out of reset
   always @(negedge clk_sys_in) begin
      if (rst_n_in) begin
         chk(sd_gnt & cs_gnt, 1'b0);
      end
   end

   initial begin
      bad_count = 0;
      checked = 0;
      {rst_n_in, pin, sd_req, sd_we, sd_strq, cs_req, cs_we, cs_smp} = 8'h0;
      cs_boot = 1'b1;
      cs_addr = 24'hffffff;
      {sd_addr, sd_wd, sd_sel, cs_size, cs_wd} = '0;
      t_shared();
      t_split();
      t_overlap();
      test_done();
   end

   initial begin
      #20000;
      bad_count++;
      $display("BAD at %0t: watchdog expired", $time);
      test_done();
   end
endmodule
